// *** include/cpr_pkg.sv ***
// control port package: constants, offsets and state types shared by both ends
// assumes a single 20 MHz system clock shared by the host end and the device end
package cpr_pkg;

	// ----------------------------------------------------------------
	// bus and timing
	// ----------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h18;
	localparam int CLK_KHZ = 20000;
	localparam int CLK_NS = 50;
	localparam int STD_KHZ = 100;
	localparam int FAST_KHZ = 400;
	localparam int STD_QCYC = (CLK_KHZ + 4 * STD_KHZ - 1) / (4 * STD_KHZ);
	localparam int FAST_QCYC = (CLK_KHZ + 4 * FAST_KHZ - 1) / (4 * FAST_KHZ);
	localparam int RST_PULSE_NS = 10;
	localparam int RST_CYC_RAW = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_CYC = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
	localparam int INIT_TIME_US = 1000;
	localparam int INIT_CYC = INIT_TIME_US * CLK_KHZ / 1000;
	localparam int PLL_TIME_US = 10000;
	localparam int PLL_CYC = PLL_TIME_US * CLK_KHZ / 1000;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int MEM_WORDS = 256;

	// ----------------------------------------------------------------
	// device register map (page, offset, bit)
	// ----------------------------------------------------------------
	localparam logic [7:0] PAGE0 = 8'h00;
	localparam logic [7:0] PAGE1 = 8'h01;
	localparam logic [6:0] REG_PAGE = 7'h00;
	localparam logic [6:0] REG_SOFT_RST = 7'h01;
	localparam logic [6:0] REG_STATUS = 7'h02;
	localparam logic [6:0] REG_CLK_PWR = 7'h05;
	localparam logic [6:0] REG_HP_RST = 7'h1F;
	localparam logic [6:0] REG_SPK_RST = 7'h20;
	localparam logic [6:0] REG_STAGE_PWR = 7'h24;
	localparam int SOFT_RST_BIT = 0;
	localparam int CLK_PWR_BIT = 7;
	localparam int HPL_RST_BIT = 7;
	localparam int HPR_RST_BIT = 6;
	localparam int SPK_RST_BIT = 7;
	localparam logic [7:0] HP_RST_MASK = 8'hC0;
	localparam logic [7:0] SPK_RST_MASK = 8'h80;
	localparam int NUM_STAGES = 4;
	localparam int STG_LEFT = 3;
	localparam int STG_RIGHT = 2;
	localparam int STG_SPEAKER_POSITIVE_STAGE = 1;
	localparam int STG_SPEAKER_NEGATIVE_STAGE = 0;

	// ----------------------------------------------------------------
	// host register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] HREG_CMD = 4'h0;
	localparam logic [3:0] HREG_STATUS = 4'h4;
	localparam logic [3:0] HREG_RESET = 4'h8;
	localparam int CMD_RD_BIT = 16;
	localparam int CMD_FAST_BIT = 17;
	localparam int RST_HOLD_BIT = 0;
	localparam int RST_PULSE_BIT = 1;
	localparam logic RST_HOLD_RST = 1'b1;

	typedef enum {DS_IDLE, DS_ADDR, DS_PTR, DS_WR, DS_ACK, DS_RD, DS_MACK} cpr_dev_state_type;
	typedef enum {HS_IDLE, HS_START, HS_BYTE, HS_STOP} cpr_host_state_type;

endpackage

// *** include/cpr_if.sv ***
// two-wire control link between the host end and the device end
// assumes both ends share i_clk_sys; the data line is open drain with a pull-up
`timescale 1ns/1ns
interface cpr_if;
	logic scl;
	logic sda;
	logic rst_n;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;

	// wired-and with pull-up
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport device (input scl, input sda, input rst_n, output dev_sda_o, output dev_sda_oe);
	modport host (output scl, output rst_n, input sda, output host_sda_o, output host_sda_oe);
endinterface // cpr_if

// *** src/cpr_bus_watch.sv ***
// start, stop and clock edge detection on the serial pins
// assumes scl and sda are synchronous to i_clk_sys
`timescale 1ns/1ns
module cpr_bus_watch (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_start,
	output logic o_stop,
	output logic o_scl_rise,
	output logic o_scl_fall
);
	logic scl_reg;
	logic scl_next;
	logic sda_reg;
	logic sda_next;

	always_comb begin
		scl_next = i_scl;
		sda_next = i_sda;
		o_start = scl_reg & i_scl & sda_reg & ~i_sda;
		o_stop = scl_reg & i_scl & ~sda_reg & i_sda;
		o_scl_rise = ~scl_reg & i_scl;
		o_scl_fall = scl_reg & ~i_scl;
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
		end else begin
			scl_reg <= scl_next;
			sda_reg <= sda_next;
		end
	end
endmodule // cpr_bus_watch

// *** src/cpr_device.sv ***
// device end: serial slave, paged register file, reset and start-up sequencing, power stages
// assumes the host end is the only master and that pins are synchronous to i_clk_sys
`timescale 1ns/1ns
module cpr_device import cpr_pkg::*; #(
	parameter int INIT_CYCLES = INIT_CYC,
	parameter int CLK_CYCLES = PLL_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	cpr_if.device bus,
	input wire logic [NUM_STAGES-1:0] i_stage_fault,
	output logic [NUM_STAGES-1:0] o_stage_on,
	output logic o_clk_ready,
	output logic o_init_busy
);
	localparam int ICW = $clog2(INIT_CYCLES + 1);
	localparam int CCW = $clog2(CLK_CYCLES + 1);

	// ----------------------------------------------------------------
	// pin events
	// ----------------------------------------------------------------
	logic start;
	logic stop;
	logic scl_rise;
	logic scl_fall;

	cpr_bus_watch cpr_bus_watch_inst (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_scl(bus.scl),
		.i_sda(bus.sda),
		.o_start(start),
		.o_stop(stop),
		.o_scl_rise(scl_rise),
		.o_scl_fall(scl_fall)
	);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	cpr_dev_state_type state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] sr_reg, sr_next;
	logic [7:0] tx_reg, tx_next;
	logic [6:0] ptr_reg, ptr_next;
	logic [7:0] page_reg, page_next;
	logic rw_reg, rw_next;
	logic have_ptr_reg, have_ptr_next;
	logic nack_reg, nack_next;
	logic oe_reg, oe_next;
	logic pend_reg, pend_next;
	logic soft_reg, soft_next;
	logic [NUM_STAGES-1:0] stg_rst_reg, stg_rst_next;
	logic [NUM_STAGES-1:0] fault_reg, fault_next;
	logic [ICW-1:0] init_reg, init_next;
	logic [CCW-1:0] clk_cnt_reg, clk_cnt_next;
	logic [7:0] mem [0:MEM_WORDS-1];
	logic mem_we;
	logic [7:0] mem_wd;
	logic [7:0] rd_byte;
	logic [7:0] status_byte;
	logic core_clr;
	logic init_busy;
	logic sweep;
	logic clk_pwr;
	logic [NUM_STAGES-1:0] stage_pwr;
	logic page0;
	logic page1;

	assign core_clr = ~bus.rst_n | soft_reg;
	assign init_busy = init_reg < ICW'(INIT_CYCLES);
	assign sweep = init_reg < ICW'(MEM_WORDS);
	assign page0 = page_reg == PAGE0;
	assign page1 = page_reg == PAGE1;
	// stale power bits during the sweep are masked by init_busy
	assign clk_pwr = mem[{1'b0, REG_CLK_PWR}][CLK_PWR_BIT] & ~init_busy;
	assign stage_pwr = mem[{1'b1, REG_STAGE_PWR}][7:4] & {NUM_STAGES{~init_busy}};
	assign status_byte = {o_clk_ready, init_busy, 2'h0, fault_reg};
	assign rd_byte = (ptr_reg == REG_PAGE) ? page_reg :
		(page0 && ptr_reg == REG_STATUS) ? status_byte : mem[{page_reg[0], ptr_reg}];
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = oe_reg;
	assign o_init_busy = init_busy;
	assign o_clk_ready = clk_cnt_reg == CCW'(CLK_CYCLES);

	// ----------------------------------------------------------------
	// serial protocol engine
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		sr_next = sr_reg;
		tx_next = tx_reg;
		ptr_next = ptr_reg;
		page_next = page_reg;
		rw_next = rw_reg;
		have_ptr_next = have_ptr_reg;
		nack_next = nack_reg;
		oe_next = oe_reg;
		pend_next = pend_reg;
		soft_next = 1'b0;
		stg_rst_next = '0;
		mem_we = 1'b0;
		mem_wd = sr_reg;
		if (scl_rise) begin
			cnt_next = cnt_reg + 4'h1;
			sr_next = {sr_reg[6:0], bus.sda};
			if (state_reg == DS_MACK)
				nack_next = bus.sda;
		end
		if (scl_fall) begin
			unique case (state_reg)
				DS_IDLE: ;
				DS_ADDR: if (cnt_reg == BYTE_BITS) begin
					if (sr_reg[7:1] == DEV_ADDR) begin
						oe_next = 1'b1;
						rw_next = sr_reg[0];
						state_next = DS_ACK;
					end else begin
						state_next = DS_IDLE;
					end
				end
				DS_PTR: if (cnt_reg == BYTE_BITS) begin
					ptr_next = sr_reg[6:0];
					have_ptr_next = 1'b1;
					oe_next = 1'b1;
					state_next = DS_ACK;
				end
				DS_WR: if (cnt_reg == BYTE_BITS) begin
					if (ptr_reg == REG_PAGE) begin
						page_next = sr_reg;
					end else if (page0 && ptr_reg == REG_SOFT_RST) begin
						// held until stop so the acknowledge of this byte completes
						pend_next = pend_reg | sr_reg[SOFT_RST_BIT];
					end else if (!(page0 && ptr_reg == REG_STATUS)) begin
						mem_we = 1'b1;
					end
					if (page1 && ptr_reg == REG_HP_RST) begin
						stg_rst_next[STG_LEFT] = sr_reg[HPL_RST_BIT];
						stg_rst_next[STG_RIGHT] = sr_reg[HPR_RST_BIT];
						mem_wd = sr_reg & ~HP_RST_MASK;
					end
					if (page1 && ptr_reg == REG_SPK_RST) begin
						stg_rst_next[STG_SPEAKER_POSITIVE_STAGE] = sr_reg[SPK_RST_BIT];
						stg_rst_next[STG_SPEAKER_NEGATIVE_STAGE] = sr_reg[SPK_RST_BIT];
						mem_wd = sr_reg & ~SPK_RST_MASK;
					end
					ptr_next = ptr_reg + 7'h01;
					oe_next = 1'b1;
					state_next = DS_ACK;
				end
				DS_ACK: begin
					oe_next = 1'b0;
					cnt_next = 4'h0;
					if (rw_reg) begin
						tx_next = rd_byte;
						oe_next = ~rd_byte[7];
						state_next = DS_RD;
					end else begin
						state_next = have_ptr_reg ? DS_WR : DS_PTR;
					end
				end
				DS_RD: if (cnt_reg == BYTE_BITS) begin
					oe_next = 1'b0;
					ptr_next = ptr_reg + 7'h01;
					state_next = DS_MACK;
				end else begin
					oe_next = ~tx_reg[3'(4'h7 - cnt_reg)];
				end
				DS_MACK: if (nack_reg) begin
					state_next = DS_IDLE;
				end else begin
					tx_next = rd_byte;
					oe_next = ~rd_byte[7];
					cnt_next = 4'h0;
					state_next = DS_RD;
				end
			endcase
		end
		if (start) begin
			state_next = DS_ADDR;
			cnt_next = 4'h0;
			oe_next = 1'b0;
			have_ptr_next = 1'b0;
		end
		if (stop) begin
			state_next = DS_IDLE;
			oe_next = 1'b0;
			soft_next = pend_reg;
			pend_next = 1'b0;
		end
		if (core_clr) begin
			state_next = DS_IDLE;
			oe_next = 1'b0;
			page_next = PAGE0;
			ptr_next = 7'h00;
			pend_next = 1'b0;
			soft_next = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= DS_IDLE;
			cnt_reg <= 4'h0;
			sr_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 7'h00;
			page_reg <= PAGE0;
			rw_reg <= 1'b0;
			have_ptr_reg <= 1'b0;
			nack_reg <= 1'b0;
			oe_reg <= 1'b0;
			pend_reg <= 1'b0;
			soft_reg <= 1'b0;
			stg_rst_reg <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			sr_reg <= sr_next;
			tx_reg <= tx_next;
			ptr_reg <= ptr_next;
			page_reg <= page_next;
			rw_reg <= rw_next;
			have_ptr_reg <= have_ptr_next;
			nack_reg <= nack_next;
			oe_reg <= oe_next;
			pend_reg <= pend_next;
			soft_reg <= soft_next;
			stg_rst_reg <= stg_rst_next;
		end
	end

	// the sweep wins the single write port; bus writes during it are lost
	always_ff @(posedge i_clk_sys) begin
		if (sweep)
			mem[init_reg[7:0]] <= 8'h00;
		else if (mem_we)
			mem[{page_reg[0], ptr_reg}] <= mem_wd;
	end

	// ----------------------------------------------------------------
	// start-up timers and power stages
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NUM_STAGES; g++) begin : g_stage
		// a fault in the same cycle as its reset stays latched
		assign fault_next[g] = i_stage_fault[g] | (fault_reg[g] & ~stg_rst_reg[g] & ~core_clr);
		assign o_stage_on[g] = stage_pwr[g] & ~fault_reg[g];
	end

	always_comb begin
		init_next = init_reg;
		if (core_clr)
			init_next = '0;
		else if (init_busy)
			init_next = init_reg + ICW'(1);
		clk_cnt_next = clk_cnt_reg;
		if (!clk_pwr || core_clr)
			clk_cnt_next = '0;
		else if (!o_clk_ready)
			clk_cnt_next = clk_cnt_reg + CCW'(1);
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			init_reg <= '0;
			clk_cnt_reg <= '0;
			fault_reg <= '0;
		end else begin
			init_reg <= init_next;
			clk_cnt_reg <= clk_cnt_next;
			fault_reg <= fault_next;
		end
	end
endmodule // cpr_device

// *** src/cpr_host.sv ***
// host end: serial master driven by Avalon-MM registers, device reset pin and lockout timers
// assumes the device end is the only slave on the link and shares i_clk_sys
`timescale 1ns/1ns
module cpr_host import cpr_pkg::*; #(
	parameter int INIT_CYCLES = INIT_CYC,
	parameter int CLK_CYCLES = PLL_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	cpr_if.host bus,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest
);
	localparam int LCW = $clog2(INIT_CYCLES + 1);
	localparam int KCW = $clog2(CLK_CYCLES + 1);

	cpr_host_state_type st_reg, st_next;
	logic [1:0] q_reg, q_next;
	logic [7:0] qc_reg, qc_next;
	logic [3:0] bit_reg, bit_next;
	logic [1:0] idx_reg, idx_next;
	logic [7:0] rx_reg, rx_next;
	logic [7:0] off_reg, off_next;
	logic [7:0] data_reg, data_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] page_reg, page_next;
	logic rd_reg, rd_next;
	logic fast_reg, fast_next;
	logic pend_reg, pend_next;
	logic err_reg, err_next;
	logic ackn_reg, ackn_next;
	logic scl_reg, scl_next;
	logic oe_reg, oe_next;
	logic hold_reg, hold_next;
	logic [1:0] pulse_reg, pulse_next;
	logic [LCW-1:0] lock_reg, lock_next;
	logic [KCW-1:0] clkw_reg, clkw_next;
	logic rack_reg, rack_next;
	logic [31:0] rdd_reg, rdd_next;
	logic tick;
	logic [7:0] txb;
	logic rst_n;

	assign rst_n = ~(hold_reg | (pulse_reg != 2'h0));
	assign tick = qc_reg == 8'h00;
	assign txb = (idx_reg == 2'h0) ? {DEV_ADDR, 1'b0} : (idx_reg == 2'h1) ? off_reg :
		(idx_reg == 2'h3) ? 8'hFF : (rd_reg ? {DEV_ADDR, 1'b1} : data_reg);
	assign bus.scl = scl_reg;
	assign bus.rst_n = rst_n;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe = oe_reg;
	assign o_avs_waitrequest = i_avs_read & ~rack_reg;
	assign o_avs_readdata = rdd_reg;

	always_comb begin
		st_next = st_reg;
		q_next = q_reg;
		qc_next = qc_reg;
		bit_next = bit_reg;
		idx_next = idx_reg;
		rx_next = rx_reg;
		off_next = off_reg;
		data_next = data_reg;
		rdata_next = rdata_reg;
		page_next = page_reg;
		rd_next = rd_reg;
		fast_next = fast_reg;
		pend_next = pend_reg;
		err_next = err_reg;
		ackn_next = ackn_reg;
		scl_next = scl_reg;
		oe_next = oe_reg;
		hold_next = hold_reg;
		pulse_next = (pulse_reg != 2'h0) ? pulse_reg - 2'h1 : 2'h0;
		lock_next = (lock_reg != '0) ? lock_reg - LCW'(1) : '0;
		clkw_next = (clkw_reg != '0) ? clkw_reg - KCW'(1) : '0;
		rack_next = i_avs_read & ~rack_reg;
		rdd_next = rdd_reg;
		if (i_avs_read && !rack_reg) begin
			unique case (i_avs_address)
				HREG_CMD: rdd_next = {14'h0, fast_reg, rd_reg, data_reg, off_reg};
				HREG_STATUS: rdd_next = {16'h0, rdata_reg, 4'h0, clkw_reg != '0, lock_reg != '0, err_reg, pend_reg};
				HREG_RESET: rdd_next = {31'h0, hold_reg};
				default: rdd_next = 32'h0;
			endcase
		end
		if (i_avs_write && i_avs_address == HREG_CMD && !pend_reg) begin
			off_next = i_avs_writedata[7:0];
			data_next = i_avs_writedata[15:8];
			rd_next = i_avs_writedata[CMD_RD_BIT];
			fast_next = i_avs_writedata[CMD_FAST_BIT];
			pend_next = 1'b1;
			err_next = 1'b0;
		end
		if (i_avs_write && i_avs_address == HREG_RESET) begin
			hold_next = i_avs_writedata[RST_HOLD_BIT];
			if (i_avs_writedata[RST_PULSE_BIT])
				pulse_next = 2'(RST_CYC);
		end
		if (!rst_n) begin
			lock_next = LCW'(INIT_CYCLES);
			clkw_next = '0;
			page_next = PAGE0;
		end
		if (st_reg != HS_IDLE)
			qc_next = tick ? 8'(fast_reg ? FAST_QCYC - 1 : STD_QCYC - 1) : qc_reg - 8'h01;
		unique case (st_reg)
			HS_IDLE: if (pend_reg && rst_n && lock_reg == '0) begin
				st_next = HS_START;
				q_next = 2'h0;
				idx_next = 2'h0;
				qc_next = 8'h00;
			end
			HS_START: if (tick) begin
				q_next = q_reg + 2'h1;
				unique case (q_reg)
					2'h0: begin scl_next = 1'b0; oe_next = 1'b0; end
					2'h1: scl_next = 1'b1;
					2'h2: oe_next = 1'b1;
					2'h3: begin scl_next = 1'b0; bit_next = 4'h0; st_next = HS_BYTE; end
				endcase
			end
			HS_BYTE: if (tick) begin
				q_next = q_reg + 2'h1;
				unique case (q_reg)
					2'h0: oe_next = (bit_reg < BYTE_BITS) ? ~txb[3'(4'h7 - bit_reg)] : 1'b0;
					2'h1: scl_next = 1'b1;
					2'h2: if (bit_reg < BYTE_BITS) rx_next = {rx_reg[6:0], bus.sda}; else ackn_next = bus.sda;
					2'h3: begin
						scl_next = 1'b0;
						bit_next = bit_reg + 4'h1;
						if (bit_reg == BYTE_BITS) begin
							bit_next = 4'h0;
							if (ackn_reg && idx_reg != 2'h3) begin
								err_next = 1'b1;
								st_next = HS_STOP;
							end else if (idx_reg == 2'h1 && rd_reg) begin
								idx_next = 2'h2;
								st_next = HS_START;
							end else if (idx_reg == 2'h3 || (idx_reg == 2'h2 && !rd_reg)) begin
								rdata_next = rx_reg;
								st_next = HS_STOP;
							end else begin
								idx_next = idx_reg + 2'h1;
							end
						end
					end
				endcase
			end
			HS_STOP: if (tick) begin
				q_next = q_reg + 2'h1;
				unique case (q_reg)
					2'h0: oe_next = 1'b1;
					2'h1: scl_next = 1'b1;
					2'h2: oe_next = 1'b0;
					2'h3: begin
						st_next = HS_IDLE;
						pend_next = 1'b0;
						if (!err_reg && !rd_reg) begin
							if (off_reg[6:0] == REG_PAGE)
								page_next = data_reg;
							if (page_reg == PAGE0 && off_reg[6:0] == REG_SOFT_RST && data_reg[SOFT_RST_BIT])
								lock_next = LCW'(INIT_CYCLES);
							if (page_reg == PAGE0 && off_reg[6:0] == REG_CLK_PWR && data_reg[CLK_PWR_BIT])
								clkw_next = KCW'(CLK_CYCLES);
						end
					end
				endcase
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= HS_IDLE;
			q_reg <= 2'h0;
			qc_reg <= 8'h00;
			bit_reg <= 4'h0;
			idx_reg <= 2'h0;
			rx_reg <= 8'h00;
			off_reg <= 8'h00;
			data_reg <= 8'h00;
			rdata_reg <= 8'h00;
			page_reg <= PAGE0;
			rd_reg <= 1'b0;
			fast_reg <= 1'b0;
			pend_reg <= 1'b0;
			err_reg <= 1'b0;
			ackn_reg <= 1'b0;
			scl_reg <= 1'b1;
			oe_reg <= 1'b0;
			hold_reg <= RST_HOLD_RST;
			pulse_reg <= 2'h0;
			lock_reg <= '0;
			clkw_reg <= '0;
			rack_reg <= 1'b0;
			rdd_reg <= 32'h0;
		end else begin
			st_reg <= st_next;
			q_reg <= q_next;
			qc_reg <= qc_next;
			bit_reg <= bit_next;
			idx_reg <= idx_next;
			rx_reg <= rx_next;
			off_reg <= off_next;
			data_reg <= data_next;
			rdata_reg <= rdata_next;
			page_reg <= page_next;
			rd_reg <= rd_next;
			fast_reg <= fast_next;
			pend_reg <= pend_next;
			err_reg <= err_next;
			ackn_reg <= ackn_next;
			scl_reg <= scl_next;
			oe_reg <= oe_next;
			hold_reg <= hold_next;
			pulse_reg <= pulse_next;
			lock_reg <= lock_next;
			clkw_reg <= clkw_next;
			rack_reg <= rack_next;
			rdd_reg <= rdd_next;
		end
	end
endmodule // cpr_host

// *** tb/cpr_props.sv ***
// checker for the two-wire link between host end and device end
// assumes one clock; watches link signals and device status pins
`timescale 1ns/1ns
module cpr_props (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic rst_n,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic [3:0] i_stage_fault,
	input wire logic [3:0] o_stage_on,
	input wire logic o_clk_ready,
	input wire logic o_init_busy
);
	// init window is 300 cycles in the bench, plus margin
	localparam int INIT_MAX = 400;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	property p_no_start; scl |-> !$rose(dev_sda_oe); endproperty
	a_no_start: assert property (p_no_start) else $error("device pulled sda with scl high");
	property p_open_drain; dev_sda_oe |-> !dev_sda_o; endproperty
	a_open_drain: assert property (p_open_drain) else $error("device drove sda high");
	property p_pin_rst; !rst_n |=> !dev_sda_oe && o_init_busy && !o_clk_ready && o_stage_on == 4'h0; endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("reset pin left state active");
	property p_init; $rose(rst_n) |-> o_init_busy[*8] ##[1:INIT_MAX] !o_init_busy; endproperty
	a_init: assert property (p_init) else $error("init window wrong");
	property p_off_init; o_init_busy |-> o_stage_on == 4'h0; endproperty
	a_off_init: assert property (p_off_init) else $error("stage on during init");
	property p_fault; |i_stage_fault |=> (o_stage_on & $past(i_stage_fault)) == 4'h0; endproperty
	a_fault: assert property (p_fault) else $error("faulted stage stayed on");
	property p_clk_wait; $rose(o_clk_ready) |-> !$past(o_clk_ready, 8) && !$past(o_init_busy, 8); endproperty
	a_clk_wait: assert property (p_clk_wait) else $error("clock ready too soon");
	property p_scl_high; $rose(scl) |-> scl[*8]; endproperty
	a_scl_high: assert property (p_scl_high) else $error("scl high too short");
	property p_scl_low; $fell(scl) |-> !scl[*8]; endproperty
	a_scl_low: assert property (p_scl_low) else $error("scl low too short");
endmodule // cpr_props

// *** tb/tb_control_port_reset_sequencing.sv ***
// self-checking bench: host end and device end joined by the link
// assumes Avalon tasks start just after a rising edge
`timescale 1ns/1ns
module tb_control_port_reset_sequencing import cpr_pkg::*;;
	localparam int INIT_P = 300;
	localparam int CLK_P = 50;
	logic i_clk_sys, i_rst, i_avs_read, i_avs_write, o_avs_waitrequest, o_clk_ready, o_init_busy;
	logic [3:0] i_avs_address, i_stage_fault, o_stage_on;
	logic [31:0] i_avs_writedata, o_avs_readdata, rd, ov;
	int n_mismatch = 0;
	int compares = 0;
	cpr_if link();
	cpr_host #(.INIT_CYCLES(INIT_P), .CLK_CYCLES(CLK_P)) cpr_host_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.bus(link.host), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest));
	cpr_device #(.INIT_CYCLES(INIT_P), .CLK_CYCLES(CLK_P)) cpr_device_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.bus(link.device), .i_stage_fault(i_stage_fault), .o_stage_on(o_stage_on), .o_clk_ready(o_clk_ready),
		.o_init_busy(o_init_busy));
	cpr_props cpr_props_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .scl(link.scl), .sda(link.sda),
		.rst_n(link.rst_n), .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .i_stage_fault(i_stage_fault),
		.o_stage_on(o_stage_on), .o_clk_ready(o_clk_ready), .o_init_busy(o_init_busy));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task end_sim;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task timeout;
		n_mismatch++;
		$display("Error at %0t: wait ran out", $time);
		end_sim;
	endtask
	// the request stands until the rising edge that samples waitrequest low; read data is taken at that edge
	task av(input logic [3:0] a, input logic r, input logic [31:0] d);
		int n;
		logic w;
		i_avs_address <= a;
		i_avs_read <= r;
		i_avs_write <= !r;
		i_avs_writedata <= d;
		n = 0;
		w = 1'b1;
		while (w !== 1'b0 && n < 20) begin
			@(posedge i_clk_sys);
			w = o_avs_waitrequest;
			rd = o_avs_readdata;
			n++;
		end
		if (w !== 1'b0) timeout;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		@(posedge i_clk_sys);
	endtask
	task poll(input int b);
		int n;
		n = 0;
		do begin
			av(HREG_STATUS, 1'b1, 32'h0);
			n++;
		end while (rd[b] !== 1'b0 && n < 4000);
		if (rd[b] !== 1'b0) timeout;
	endtask
	task cmd(input logic [6:0] off, input logic [7:0] dat, input logic r, input logic f);
		av(HREG_CMD, 1'b0, {14'h0, f, r, dat, 1'b0, off});
		poll(0);
	endtask
	task rdchk(input logic [6:0] off, input logic [7:0] exp, input logic f);
		cmd(off, 8'h00, 1'b1, f);
		chk({24'h0, rd[15:8]}, {24'h0, exp});
	endtask
	task obs;
		@(negedge i_clk_sys);
		ov = {26'h0, o_init_busy, o_clk_ready, o_stage_on};
		@(posedge i_clk_sys);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reset;
		av(HREG_RESET, 1'b1, 32'h0);
		chk(rd, {31'h0, RST_HOLD_RST});
		obs;
		chk(ov, 32'h20);
		av(HREG_RESET, 1'b0, 32'h0);
		poll(2);
		repeat (4) @(posedge i_clk_sys);
		obs;
		chk(ov, 32'h0);
		av(4'hC, 1'b1, 32'h0);
		chk(rd, 32'h0);
		$display("test reset done");
	endtask
	task t_stage;
		cmd(REG_PAGE, PAGE1, 1'b0, 1'b1);
		cmd(REG_STAGE_PWR, 8'hF0, 1'b0, 1'b1);
		obs;
		chk(ov, 32'h0F);
		rdchk(REG_STAGE_PWR, 8'hF0, 1'b0);
		i_stage_fault <= 4'hF;
		@(posedge i_clk_sys);
		i_stage_fault <= 4'h0;
		obs;
		chk(ov, 32'h0);
		cmd(REG_HP_RST, 8'h85, 1'b0, 1'b1);
		obs;
		chk(ov, 32'h08);
		cmd(REG_HP_RST, 8'h45, 1'b0, 1'b1);
		obs;
		chk(ov, 32'h0C);
		cmd(REG_SPK_RST, SPK_RST_MASK, 1'b0, 1'b1);
		obs;
		chk(ov, 32'h0F);
		rdchk(REG_STAGE_PWR, 8'hF0, 1'b1);
		rdchk(REG_HP_RST, 8'h05, 1'b1);
		cmd(REG_STAGE_PWR, 8'h00, 1'b0, 1'b1);
		obs;
		chk(ov, 32'h0);
		rdchk(REG_HP_RST, 8'h05, 1'b1);
		$display("test stages done");
	endtask
	task t_clk_soft;
		int n;
		cmd(REG_PAGE, PAGE0, 1'b0, 1'b1);
		cmd(REG_CLK_PWR, 8'h80, 1'b0, 1'b1);
		n = 0;
		do begin
			obs;
			n++;
		end while (ov[4] !== 1'b1 && n < 200);
		chk(ov, 32'h10);
		cmd(REG_SOFT_RST, 8'h01, 1'b0, 1'b1);
		obs;
		chk(ov, 32'h20);
		poll(2);
		rdchk(REG_CLK_PWR, 8'h00, 1'b1);
		av(HREG_CMD, 1'b1, 32'h0);
		chk(rd, 32'h0003_0005);
		av(HREG_RESET, 1'b0, 32'h2);
		// the pulse is registered at the edge that takes the write and reaches the device at the next one
		@(posedge i_clk_sys);
		obs;
		chk(ov, 32'h20);
		poll(2);
		$display("test clock and resets done");
	endtask
	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		i_rst = 1'b1;
		i_avs_address = 4'h0;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_writedata = 32'h0;
		i_stage_fault = 4'h0;
		repeat (8) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		t_reset;
		t_stage;
		t_clk_soft;
		end_sim;
	end
endmodule // tb_control_port_reset_sequencing
